// ==== pkg/refclk_defs.vh ====
// Constants for the reference clock output and clock-control block
`ifndef REFCLK_DEFS_VH
`define REFCLK_DEFS_VH

// Register byte offsets (low address bits)
`define OFS_REF_CTRL     8'h00
`define OFS_OSC_CTRL     8'h04
`define OFS_OSC_CONFIG   8'h08
`define OFS_CLK_STATUS   8'h0C

// Reference output control fields
`define REF_EN_BIT       7
`define REF_RSVD_BIT     6
`define REF_SLP_BIT      5
`define REF_SEL_BIT      4
`define REF_DIV_MSB      3
`define REF_DIV_LSB      0
`define REF_CTRL_RESET   8'h00
`define REF_CTRL_WMASK   8'hBF

// Oscillator control fields
`define HALT_SEL_BIT     7
`define SRC_SEL_MSB      1
`define SRC_SEL_LSB      0
`define OSC_CTRL_RESET   8'h00
`define SRC_PRIMARY      2'h0
`define SRC_SECONDARY    2'h1

// Oscillator configuration field and codes
`define CFG_MSB          1
`define CFG_LSB          0
`define CFG_RESET        2'h0
`define CFG_EXT_CLOCK    2'h0
`define CFG_CRYSTAL_FAST 2'h1
`define CFG_INTERNAL     2'h2
`define CFG_CRYSTAL_SLOW 2'h3

// Timing
`define CLK_FREQ_KHZ     100000
`define POWER_UP_TIMER_TIME_MS     64
`define OST_OSC_CYCLES   11'h400
`define OSC2_HALF_EDGES  1'h1

`endif

// ==== logic/sync_two_stage.v ====
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/100ps
module sync_two_stage #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] stable_r;

  always @(posedge clk)
  begin
    if (reset)
    begin
      meta_r   <= {WIDTH{1'b0}};
      stable_r <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r   <= d;
      stable_r <= meta_r;
    end
  end

  assign q = stable_r;
endmodule

// ==== logic/refclk_out.v ====
// Reference clock output, power-mode clock gating and power-up timers
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
`include "refclk_defs.vh"
module refclk_out #(
  parameter DIV_WIDTH   = 4,
  parameter CNT_WIDTH   = 15,
  parameter POWER_UP_TIMER_WIDTH  = 23,
  parameter POWER_UP_TIMER_CYCLES = `POWER_UP_TIMER_TIME_MS * `CLK_FREQ_KHZ
) (
  input  wire        CORE_CLK,
  input  wire        RESET,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output wire        HREADYOUT,
  output wire [31:0] HRDATA,
  output wire        HRESP,
  input  wire        PRIMARY_OSC_IN,
  input  wire        SYSTEM_CLK_IN,
  input  wire        SLEEP_CMD,
  input  wire        WAKE_EVENT,
  output wire        REF_CLK_PIN_OUT,
  output wire        REF_CLK_PIN_OE,
  output wire        OSC2_PIN_OUT,
  output wire        OSC2_PIN_OE,
  output wire        PRIMARY_OSC_EN,
  output wire        SECONDARY_OSC_EN,
  output wire        INTERNAL_OSC_EN,
  output wire        CPU_CLK_EN,
  output wire        PERIPH_CLK_EN,
  output wire        DEVICE_RESET_HOLD
);
  localparam [2:0] ST_RUN   = 3'b001;
  localparam [2:0] ST_IDLE  = 3'b010;
  localparam [2:0] ST_SLEEP = 3'b100;
  localparam [31:0]           POWER_UP_TIMER_SPAN = POWER_UP_TIMER_CYCLES - 1;
  localparam [POWER_UP_TIMER_WIDTH-1:0] POWER_UP_TIMER_LAST = POWER_UP_TIMER_SPAN[POWER_UP_TIMER_WIDTH-1:0];

  // Registers
  reg  [7:0]           ref_ctrl_r;
  reg  [7:0]           osc_ctrl_r;
  reg  [1:0]           osc_cfg_r;
  reg  [2:0]           state_r;
  reg  [2:0]           state_nxt;
  reg                  wr_pend_r;
  reg  [7:0]           wr_addr_r;
  reg  [31:0]          rdata_r;
  reg  [31:0]          rdata_nxt;
  reg                  prim_prev_r;
  reg                  sys_prev_r;
  reg  [CNT_WIDTH-1:0] div_cnt_r;
  reg                  ref_out_r;
  reg                  ref_oe_r;
  reg  [DIV_WIDTH-1:0] div_seen_r;
  reg                  ref_live_r;
  reg  [POWER_UP_TIMER_WIDTH-1:0] power_up_timer_cnt_r;
  reg                  power_up_timer_busy_r;
  reg  [10:0]          ost_cnt_r;
  reg                  ost_busy_r;
  reg                  prim_en_prev_r;
  reg                  osc2_phase_r;
  reg                  osc2_out_r;
  reg                  osc2_oe_r;

  wire                 prim_q;
  wire                 sys_q;
  wire                 ref_keep_sleep;
  wire                 ref_active;
  wire                 prim_en;

  // Oscillator and system clock levels come from outside the domain
  sync_two_stage #(
    .WIDTH (2)
  ) u_clk_sync (
    .clk   (CORE_CLK),
    .reset (RESET),
    .d     ({PRIMARY_OSC_IN, SYSTEM_CLK_IN}),
    .q     ({prim_q, sys_q})
  );

  wire                 prim_rise      = prim_q & ~prim_prev_r;
  wire                 sys_rise       = sys_q & ~sys_prev_r;

  // Field views
  wire [DIV_WIDTH-1:0] div_code       = ref_ctrl_r[`REF_DIV_MSB:`REF_DIV_LSB];
  wire                 ref_en         = ref_ctrl_r[`REF_EN_BIT];
  wire                 ref_slp        = ref_ctrl_r[`REF_SLP_BIT];
  wire                 ref_sel        = ref_ctrl_r[`REF_SEL_BIT];
  wire                 halt_sel       = osc_ctrl_r[`HALT_SEL_BIT];
  wire [1:0]           src_sel        = osc_ctrl_r[`SRC_SEL_MSB:`SRC_SEL_LSB];
  wire                 cfg_is_ext     = (osc_cfg_r == `CFG_EXT_CLOCK);
  wire                 cfg_is_crystal = (osc_cfg_r == `CFG_CRYSTAL_FAST) |
                                        (osc_cfg_r == `CFG_CRYSTAL_SLOW);
  wire                 cfg_primary_ok = cfg_is_ext | (osc_cfg_r == `CFG_CRYSTAL_FAST);
  wire                 in_run         = state_r[0];
  wire                 in_idle        = state_r[1];
  wire                 in_sleep       = state_r[2];
  wire                 hold           = power_up_timer_busy_r | ost_busy_r;

  // AHB-Lite slave: zero wait states, always OKAY
  wire                 addr_phase     = HSEL & HTRANS[1] & HREADY;
  wire [7:0]           addr_lo        = HADDR[7:0];
  assign HREADYOUT  = 1'b1;
  assign HRESP      = 1'b0;
  assign HRDATA     = rdata_r;

  // Read data registered in the address phase, unmapped reads zero
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    if (addr_lo == `OFS_REF_CTRL)
      rdata_nxt[7:0] = ref_ctrl_r & `REF_CTRL_WMASK;
    else if (addr_lo == `OFS_OSC_CTRL)
      rdata_nxt[7:0] = osc_ctrl_r;
    else if (addr_lo == `OFS_OSC_CONFIG)
      rdata_nxt[1:0] = osc_cfg_r;
    else if (addr_lo == `OFS_CLK_STATUS)
      rdata_nxt[7:0] = {ref_out_r, ref_active, power_up_timer_busy_r, ost_busy_r,
                        prim_en, state_r};
  end

  always @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= addr_phase & HWRITE;
      if (addr_phase)
        wr_addr_r <= addr_lo;
      if (addr_phase & ~HWRITE)
        rdata_r <= rdata_nxt;
    end
  end

  // Register writes in the data phase
  always @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      ref_ctrl_r <= `REF_CTRL_RESET;
      osc_ctrl_r <= `OSC_CTRL_RESET;
      osc_cfg_r  <= `CFG_RESET;
    end
    else if (wr_pend_r)
    begin
      if (wr_addr_r == `OFS_REF_CTRL)
        ref_ctrl_r <= HWDATA[7:0] & `REF_CTRL_WMASK;
      else if (wr_addr_r == `OFS_OSC_CTRL)
        osc_ctrl_r <= {HWDATA[`HALT_SEL_BIT], 5'h00,
                       HWDATA[`SRC_SEL_MSB:`SRC_SEL_LSB]};
      else if (wr_addr_r == `OFS_OSC_CONFIG)
        osc_cfg_r <= HWDATA[`CFG_MSB:`CFG_LSB];
    end
  end

  // Power-mode state machine
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
        if (SLEEP_CMD & ~hold)
          state_nxt = halt_sel ? ST_IDLE : ST_SLEEP;
      ST_IDLE:
        if (WAKE_EVENT)
          state_nxt = ST_RUN;
        else if (SLEEP_CMD)
          state_nxt = halt_sel ? ST_IDLE : ST_SLEEP;
      ST_SLEEP:
        if (WAKE_EVENT)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_RUN;
    endcase
  end

  always @(posedge CORE_CLK)
  begin
    if (RESET)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // Oscillator and clock gating
  // sleep keeps primary only as a reference base
  assign ref_keep_sleep = ref_en & ref_slp & ref_sel & cfg_primary_ok;
  // primary runs in primary run or primary idle
  // sleep stops all except the reference feature
  assign prim_en = ((in_run | in_idle) & (src_sel == `SRC_PRIMARY)) |
                   (in_sleep & ref_keep_sleep);
  assign PRIMARY_OSC_EN   = prim_en;
  assign SECONDARY_OSC_EN = (in_run | in_idle) & (src_sel == `SRC_SECONDARY);
  // Power-up timer needs the internal oscillator
  assign INTERNAL_OSC_EN  = ((in_run | in_idle) & src_sel[1]) | power_up_timer_busy_r;
  assign CPU_CLK_EN       = in_run & ~hold;
  assign PERIPH_CLK_EN    = (in_run | in_idle) & ~hold;
  assign DEVICE_RESET_HOLD = hold;

  always @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      power_up_timer_cnt_r  <= {POWER_UP_TIMER_WIDTH{1'b0}};
      power_up_timer_busy_r <= 1'b1;
    end
    else if (power_up_timer_busy_r)
    begin
      power_up_timer_cnt_r <= power_up_timer_cnt_r + 1'b1;
      if (power_up_timer_cnt_r == POWER_UP_TIMER_LAST)
        power_up_timer_busy_r <= 1'b0;
    end
  end

  // start-up timer counts crystal edges on each primary oscillator start in a crystal configuration
  always @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      prim_en_prev_r <= 1'b0;
      ost_cnt_r      <= 11'h000;
      ost_busy_r     <= 1'b0;
    end
    else
    begin
      prim_en_prev_r <= prim_en;
      if (prim_en & ~prim_en_prev_r & cfg_is_crystal)
      begin
        ost_cnt_r  <= 11'h000;
        ost_busy_r <= 1'b1;
      end
      else if (ost_busy_r & prim_rise)
      begin
        ost_cnt_r <= ost_cnt_r + 11'h001;
        if (ost_cnt_r == `OST_OSC_CYCLES - 11'h001)
          ost_busy_r <= 1'b0;
      end
    end
  end

  // Reference base selection
  // primary base
  wire                 base_lvl       = ref_sel ? prim_q : sys_q;
  wire                 base_rise      = ref_sel ? prim_rise : sys_rise;
  // Primary base needs the primary oscillator running
  wire                 prim_en_ok_w   = ~ref_sel | prim_en;
  // primary must be the configured oscillator
  assign ref_active = ref_en & (~ref_sel | cfg_primary_ok) &
                      (~in_sleep | ref_keep_sleep) & prim_en_ok_w;

  // half-period in base edges is two to the code minus one
  wire [CNT_WIDTH:0]   div_one        = {{CNT_WIDTH{1'b0}}, 1'b1} << div_code;
  wire [CNT_WIDTH-1:0] half_last      = div_one[CNT_WIDTH:1] - {{(CNT_WIDTH-1){1'b0}}, 1'b1};

  always @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      prim_prev_r <= 1'b0;
      sys_prev_r  <= 1'b0;
      div_cnt_r   <= {CNT_WIDTH{1'b0}};
      div_seen_r  <= {DIV_WIDTH{1'b0}};
      ref_live_r  <= 1'b0;
      ref_out_r   <= 1'b0;
      ref_oe_r    <= 1'b0;
    end
    else
    begin
      prim_prev_r <= prim_q;
      sys_prev_r  <= sys_q;
      div_seen_r  <= div_code;
      ref_live_r  <= ref_active;
      ref_oe_r    <= ref_en;
      // Restart on divisor change; clearing the output can cut a high half-cycle short
      if (~ref_active | (div_seen_r != div_code) | ~ref_live_r)
      begin
        div_cnt_r <= {CNT_WIDTH{1'b0}};
        ref_out_r <= 1'b0;
      end
      // code zero passes the base through
      else if (div_code == {DIV_WIDTH{1'b0}})
        ref_out_r <= base_lvl;
      // toggle on base edges for even duty
      else if (base_rise)
      begin
        if (div_cnt_r == half_last)
        begin
          div_cnt_r <= {CNT_WIDTH{1'b0}};
          ref_out_r <= ~ref_out_r;
        end
        else
          div_cnt_r <= div_cnt_r + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  assign REF_CLK_PIN_OUT = ref_out_r;
  assign REF_CLK_PIN_OE  = ref_oe_r;

  // Second oscillator pin: clock/4 in external clock mode
  always @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      osc2_phase_r <= 1'b0;
      osc2_out_r   <= 1'b0;
      osc2_oe_r    <= 1'b0;
    end
    else
    begin
      osc2_oe_r <= cfg_is_ext;
      // held low in sleep with external clock
      if (~cfg_is_ext | in_sleep)
      begin
        osc2_phase_r <= 1'b0;
        osc2_out_r   <= 1'b0;
      end
      else if (prim_rise)
      begin
        osc2_phase_r <= ~osc2_phase_r;
        if (osc2_phase_r == `OSC2_HALF_EDGES)
          osc2_out_r <= ~osc2_out_r;
      end
    end
  end

  assign OSC2_PIN_OUT = osc2_out_r;
  assign OSC2_PIN_OE  = osc2_oe_r;
endmodule

// ==== sim/refclk_out_assertions.sv ====
// Port-level assertions for the reference clock output block
`timescale 1ns/100ps
module refclk_out_checker (
  input logic CORE_CLK,
  input logic RESET,
  input logic SLEEP_CMD,
  input logic WAKE_EVENT,
  input logic REF_CLK_PIN_OUT,
  input logic REF_CLK_PIN_OE,
  input logic OSC2_PIN_OUT,
  input logic OSC2_PIN_OE,
  input logic PRIMARY_OSC_EN,
  input logic SECONDARY_OSC_EN,
  input logic INTERNAL_OSC_EN,
  input logic CPU_CLK_EN,
  input logic PERIPH_CLK_EN,
  input logic DEVICE_RESET_HOLD
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // Both gates off outside a hold can only mean Sleep
  wire asleep = !PERIPH_CLK_EN && !DEVICE_RESET_HOLD;
  AST_PIN_OFF: assert property (!REF_CLK_PIN_OE |-> !REF_CLK_PIN_OUT)
    else $error("pin high while not driven");
  AST_RESET_HOLD: assert property ($fell(RESET) |-> DEVICE_RESET_HOLD)
    else $error("no hold after reset");
  AST_HOLD_GATES: assert property (DEVICE_RESET_HOLD |-> !CPU_CLK_EN && !PERIPH_CLK_EN)
    else $error("clocks run during hold");
  AST_CPU_PERIPH: assert property (CPU_CLK_EN |-> PERIPH_CLK_EN)
    else $error("cpu clocked without peripherals");
  AST_SLEEP_ENTRY: assert property (SLEEP_CMD && CPU_CLK_EN |=> !CPU_CLK_EN)
    else $error("cpu still clocked after sleep");
  AST_WAKE: assert property (WAKE_EVENT && !CPU_CLK_EN && !DEVICE_RESET_HOLD
    |=> CPU_CLK_EN || DEVICE_RESET_HOLD) else $error("no wake");
  AST_SLEEP_OSCS: assert property (asleep |-> !SECONDARY_OSC_EN && !INTERNAL_OSC_EN)
    else $error("oscillator on in sleep");
  AST_SLEEP_REF: assert property ((asleep && !PRIMARY_OSC_EN)[*3] |-> !REF_CLK_PIN_OUT)
    else $error("reference runs in sleep");
  AST_OSC2_SLEEP: assert property ((asleep && OSC2_PIN_OE)[*3] |-> !OSC2_PIN_OUT)
    else $error("second pin not low in sleep");
  COV_SLEEP_KEEP: cover property (asleep && PRIMARY_OSC_EN);
  COV_IDLE: cover property (PERIPH_CLK_EN && !CPU_CLK_EN);
  COV_REF: cover property ($rose(REF_CLK_PIN_OUT));
endmodule

bind refclk_out refclk_out_checker chk_u (.CORE_CLK, .RESET, .SLEEP_CMD, .WAKE_EVENT,
  .REF_CLK_PIN_OUT, .REF_CLK_PIN_OE, .OSC2_PIN_OUT, .OSC2_PIN_OE, .PRIMARY_OSC_EN,
  .SECONDARY_OSC_EN, .INTERNAL_OSC_EN, .CPU_CLK_EN, .PERIPH_CLK_EN, .DEVICE_RESET_HOLD);

// ==== sim/ref_probe.sv ====
// External device sampling the reference pin on the core clock, measuring what it gets
`timescale 1ns/100ps
module ref_probe (
  input  logic        clk,
  input  logic        pin,
  input  logic        oe,
  output logic [31:0] edges,
  output logic [31:0] period,
  output logic [31:0] high_t
);
  logic        prev;
  logic [31:0] cnt;
  logic [31:0] hcnt;
  // Board pull-down: an undriven pin reads low
  wire lvl = oe & pin;
  initial
  begin
    {prev, edges, period, high_t, cnt, hcnt} = 0;
  end
  always @(posedge clk)
  begin
    prev <= lvl;
    cnt  <= cnt + 1;
    hcnt <= hcnt + 1;
    if (lvl && !prev)
    begin
      edges  <= edges + 1;
      period <= cnt;
      cnt    <= 1;
      hcnt   <= 1;
    end
    if (!lvl && prev)
      high_t <= hcnt;
  end
endmodule

// ==== sim/refclk_out_tb.sv ====
// Self-checking testbench for the reference clock output block
`timescale 1ns/100ps
module refclk_out_tb;
  localparam PW = 20;
  logic        CORE_CLK = 0;
  logic        RESET = 1;
  logic        HSEL = 0;
  logic [31:0] HADDR = 0;
  logic [1:0]  HTRANS = 0;
  logic        HWRITE = 0;
  logic [2:0]  HSIZE = 3'h2;
  logic [31:0] HWDATA = 0;
  logic        PRIMARY_OSC_IN = 0;
  logic        SYSTEM_CLK_IN = 0;
  logic        SLEEP_CMD = 0;
  logic        WAKE_EVENT = 0;
  wire         HREADYOUT, HRESP, REF_CLK_PIN_OUT, REF_CLK_PIN_OE, OSC2_PIN_OUT, OSC2_PIN_OE;
  wire         PRIMARY_OSC_EN, SECONDARY_OSC_EN, INTERNAL_OSC_EN, CPU_CLK_EN, PERIPH_CLK_EN;
  wire         DEVICE_RESET_HOLD;
  wire [31:0]  HRDATA, edges, period, high_t;
  int          err_total = 0, cmp_count = 0, cyc = 0, pc = 0, sc = 0, sys_half = 8;
  logic [31:0] rd, e0;

  refclk_out #(.POWER_UP_TIMER_CYCLES(PW)) dut_u (.CORE_CLK, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HREADYOUT, .HRDATA, .HRESP, .PRIMARY_OSC_IN,
    .SYSTEM_CLK_IN, .SLEEP_CMD, .WAKE_EVENT, .REF_CLK_PIN_OUT, .REF_CLK_PIN_OE,
    .OSC2_PIN_OUT, .OSC2_PIN_OE, .PRIMARY_OSC_EN, .SECONDARY_OSC_EN, .INTERNAL_OSC_EN,
    .CPU_CLK_EN, .PERIPH_CLK_EN, .DEVICE_RESET_HOLD);
  ref_probe probe_u (.clk(CORE_CLK), .pin(REF_CLK_PIN_OUT), .oe(REF_CLK_PIN_OE),
    .edges(edges), .period(period), .high_t(high_t));

  always #5 CORE_CLK = ~CORE_CLK;

  // Oscillators in step with the core clock keep measured periods exact
  always @(posedge CORE_CLK)
  begin
    pc <= (pc == 3) ? 0 : pc + 1;
    sc <= (sc >= sys_half - 1) ? 0 : sc + 1;
    if (pc == 3)
      PRIMARY_OSC_IN <= ~PRIMARY_OSC_IN;
    if (sc >= sys_half - 1)
      SYSTEM_CLK_IN <= ~SYSTEM_CLK_IN;
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      final_report;
    end
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    HSEL   <= 1'h1;
    HADDR  <= {24'h00_0000, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'h1);
    HTRANS <= 2'h0;
    HWDATA <= {24'h00_0000, d};
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'h1);
    rd = HRDATA;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    bus(1'h0, a, 8'h00);
    chk(rd, {24'h00_0000, exp});
  endtask

  task automatic pm(input logic s);
    @(posedge CORE_CLK);
    SLEEP_CMD  <= s;
    WAKE_EVENT <= !s;
    @(posedge CORE_CLK);
    SLEEP_CMD  <= 1'h0;
    WAKE_EVENT <= 1'h0;
    repeat (2) @(posedge CORE_CLK);
  endtask

  // Third fresh edge skips any period cut short by the change
  task automatic meas(input int p);
    int n;
    n = 0;
    e0 = edges;
    while (edges < e0 + 3 && n < 3000)
    begin
      @(posedge CORE_CLK);
      n++;
    end
    chk(period, p);
    chk(high_t, p / 2);
  endtask

  task automatic quiet;
    // Let a rise launched before the change reach the probe first
    repeat (2) @(posedge CORE_CLK);
    e0 = edges;
    repeat (300) @(posedge CORE_CLK);
    chk(edges, e0);
    chk(REF_CLK_PIN_OUT, 1'h0);
  endtask

  task automatic hold(output int n);
    n = 3;
    repeat (3) @(posedge CORE_CLK);
    while (DEVICE_RESET_HOLD !== 1'h0 && n < 9000)
    begin
      @(posedge CORE_CLK);
      n++;
    end
  endtask

  initial
  begin
    int n;
    repeat (6) @(posedge CORE_CLK);
    RESET <= 1'h0;
    @(posedge CORE_CLK);
    chk({DEVICE_RESET_HOLD, CPU_CLK_EN}, 2'h2);
    hold(n);
    chk(n >= PW - 3 && n <= PW + 2, 1'h1);
    rc(8'h00, 8'h00);
    wr(8'h00, 8'hFF);
    rc(8'h00, 8'hBF);
    rc(8'h10, 8'h00);
    for (int c = 0; c < 6; c++)
    begin
      wr(8'h00, {4'h9, c[3:0]});
      meas(8 << c);
    end
    chk(REF_CLK_PIN_OE, 1'h1);
    wr(8'h00, 8'h81);
    meas(32);
    sys_half <= 4;
    meas(16);
    wr(8'h00, 8'h01);
    quiet;
    chk(REF_CLK_PIN_OE, 1'h0);
    wr(8'h08, 8'h02);
    wr(8'h00, 8'h91);
    quiet;
    wr(8'h08, 8'h00);
    // keep and primary base set before sleeping
    wr(8'h00, 8'hB1);
    pm(1'h1);
    chk(PERIPH_CLK_EN, 1'h0);
    meas(16);
    chk(OSC2_PIN_OUT, 1'h0);
    pm(1'h0);
    wr(8'h00, 8'h91);
    pm(1'h1);
    quiet;
    pm(1'h0);
    wr(8'h04, 8'h80);
    pm(1'h1);
    chk({CPU_CLK_EN, PERIPH_CLK_EN, PRIMARY_OSC_EN}, 3'h3);
    pm(1'h0);
    wr(8'h04, 8'h81);
    chk({PRIMARY_OSC_EN, SECONDARY_OSC_EN}, 2'h1);
    pm(1'h1);
    chk({PERIPH_CLK_EN, PRIMARY_OSC_EN}, 2'h2);
    pm(1'h0);
    wr(8'h04, 8'h02);
    chk({PRIMARY_OSC_EN, INTERNAL_OSC_EN}, 2'h1);
    wr(8'h04, 8'h01);
    wr(8'h08, 8'h01);
    wr(8'h04, 8'h00);
    hold(n);
    chk(n >= 8180 && n <= 8200, 1'h1);
    final_report;
  end
endmodule
